// ===== hw/ftsr_pkg.sv
// package: register map, field layout and timing constants for the flash timebase block
`default_nettype none
package ftsr_pkg;
    // register word offsets on the avalon bus (byte addresses)
    localparam logic [3:0] RatioOffset = 4'h0;
    localparam logic [3:0] OptionOffset = 4'h4;
    localparam logic [3:0] ConfigOffset = 4'h8;
    localparam logic [3:0] StatusOffset = 4'hC;
    // ratio register fields
    localparam int RatioLoadedBit = 7;
    localparam int PrescaleBit = 6;
    localparam int RatioMsb = 5;
    // option register fields
    localparam int UnlockAllowBit = 7;
    localparam int RedirectOffBit = 6;
    localparam logic [1:0] SecUnsecured = 2'h2;
    // config register fields
    localparam int KeyModeBit = 5;
    // key window and key length
    localparam logic [2:0] KeyLastIdx = 3'h7;
    localparam int KeyBytes = 8;
    // prescaler last count, prescale divides by 8
    localparam logic [2:0] PrescaleLast = 3'h7;
    // reset values
    localparam logic [7:0] RatioReset = 8'h00;
    localparam logic [7:0] ConfigReset = 8'h00;
    localparam logic [7:0] OptionReset = 8'hFF;
    // timebase window, from the clock rate
    localparam int ClockKhz = 25000;
    localparam int PulseMinNs = 5000;
    localparam int PulseMaxNs = 6700;
    localparam int PulseMinCycles = (PulseMinNs * ClockKhz + 999999) / 1000000;
    localparam int PulseMaxCycles = (PulseMaxNs * ClockKhz) / 1000000;
    // key compare states, gray coded along idle, load, done
    typedef enum logic [1:0] {
        FTSR_KEY_IDLE = 2'b00,
        FTSR_KEY_LOAD = 2'b01,
        FTSR_KEY_DONE = 2'b11
    } ftsr_key_state_t;
endpackage
`default_nettype wire

// ===== hw/ftsr_tick_if.sv
// interface: divider settings in, timebase pulse out
`default_nettype none
interface ftsr_tick_if;
    logic enable;
    logic prescale;
    logic [5:0] ratio;
    logic tick;
    modport ctrl (output enable, output prescale, output ratio, input tick);
    modport div (input enable, input prescale, input ratio, output tick);
endinterface
`default_nettype wire

// ===== hw/ftsr_timebase.sv
// module: prescaler and ratio divider making the nonvolatile memory timebase
`default_nettype none
module ftsr_timebase (
    input wire logic sys_clk,
    input wire logic rstn,
    ftsr_tick_if.div tb
);
    logic [2:0] preCnt_r, preCnt_nxt;
    logic [5:0] divCnt_r, divCnt_nxt;
    logic tick_r, tick_nxt;
    logic preEn;

    ////////////////////////////////////////////////////////////////////////
    // divider next state
    always_comb begin
        preCnt_nxt = preCnt_r;
        divCnt_nxt = divCnt_r;
        tick_nxt = 1'b0;
        preEn = 1'b1;
        if (tb.prescale) begin
            preEn = (preCnt_r == ftsr_pkg::PrescaleLast);
        end
        if (!tb.enable) begin
            preCnt_nxt = 3'h0;
            divCnt_nxt = 6'h00;
        end else begin
            preCnt_nxt = preCnt_r + 3'h1;
            if (preEn) begin
                if (divCnt_r >= tb.ratio) begin
                    divCnt_nxt = 6'h00;
                    tick_nxt = 1'b1;
                end else begin
                    divCnt_nxt = divCnt_r + 6'h01;
                end
            end
        end
    end

    // divider registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            preCnt_r <= 3'h0;
            divCnt_r <= 6'h00;
            tick_r <= 1'b0;
        end else begin
            preCnt_r <= preCnt_nxt;
            divCnt_r <= divCnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tb.tick = tick_r;
endmodule
`default_nettype wire

// ===== hw/flash_timebase_security_regs.sv
// module: flash timebase divider, option shadow and key compare registers
`default_nettype none
module flash_timebase_security_regs (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] option_nv_byte,
    input wire logic [63:0] backdoor_key_bytes,
    input wire logic keyWrite,
    input wire logic [2:0] keyIndex,
    input wire logic [7:0] keyData,
    input wire logic keySrcSecure,
    input wire logic blankCheckPass,
    input wire logic memAccessReq,
    input wire logic memSrcSecure,
    input wire logic progEraseReq,
    output logic progEraseGrant,
    output logic progEraseRefused,
    output logic cmdStart,
    output logic memAccessAllow,
    output logic vectorRedirectOn,
    output logic timebasePulse
);
    ftsr_tick_if tb ();

    logic [7:0] ratio_r, ratio_nxt;
    logic [7:0] option_r, option_nxt;
    logic [7:0] config_r, config_nxt;
    logic optLoaded_r, optLoaded_nxt;
    logic [63:0] keyBuf_r, keyBuf_nxt;
    logic [3:0] keyCount_r, keyCount_nxt;
    logic keyOrderOk_r, keyOrderOk_nxt;
    ftsr_pkg::ftsr_key_state_t keyState_r, keyState_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wait_r, wait_nxt;
    logic grant_r, grant_nxt;
    logic refused_r, refused_nxt;
    logic cmd_r, cmd_nxt;
    logic memAllow_r, memAllow_nxt;
    logic redirect_r, redirect_nxt;
    logic pulse_r;
    logic busWr, busRd, keyModeFall;

    // security code decode, used by the memory access gate
    function automatic logic isSecure(input logic [1:0] code);
        isSecure = (code != ftsr_pkg::SecUnsecured);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // timebase divider
    assign tb.enable = ratio_r[ftsr_pkg::RatioLoadedBit];
    assign tb.prescale = ratio_r[ftsr_pkg::PrescaleBit];
    assign tb.ratio = ratio_r[ftsr_pkg::RatioMsb:0];

    ftsr_timebase u_timebase (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .tb(tb)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus strobes: one wait cycle, accept on second cycle
    // read data captured in the wait cycle, so it stands at the accepting edge
    assign busWr = avs_write && wait_r == 1'b0;
    assign busRd = avs_read && wait_r == 1'b1;
    assign keyModeFall = busWr && avs_address == ftsr_pkg::ConfigOffset
        && config_r[ftsr_pkg::KeyModeBit] && !avs_writedata[ftsr_pkg::KeyModeBit];

    // register file next state
    always_comb begin
        ratio_nxt = ratio_r;
        config_nxt = config_r;
        rdata_nxt = rdata_r;
        wait_nxt = 1'b1;
        if ((avs_read || avs_write) && wait_r) begin
            wait_nxt = 1'b0;
        end
        if (busWr) begin
            unique case (avs_address)
                ftsr_pkg::RatioOffset: begin
                    if (!ratio_r[ftsr_pkg::RatioLoadedBit]) begin
                        ratio_nxt = {1'b1, avs_writedata[6:0]};
                    end
                end
                ftsr_pkg::ConfigOffset: begin
                    config_nxt = {2'b00, avs_writedata[ftsr_pkg::KeyModeBit], 5'h00};
                end
                default: begin
                    // option shadow and status ignore writes
                end
            endcase
        end
        if (busRd) begin
            unique case (avs_address)
                ftsr_pkg::RatioOffset: rdata_nxt = {24'h000000, ratio_r};
                ftsr_pkg::OptionOffset: rdata_nxt = {24'h000000, option_r};
                ftsr_pkg::ConfigOffset: rdata_nxt = {24'h000000, config_r};
                ftsr_pkg::StatusOffset: rdata_nxt = {28'h0000000, keyCount_r};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
    end

    // register file registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ratio_r <= ftsr_pkg::RatioReset;
            config_r <= ftsr_pkg::ConfigReset;
            rdata_r <= 32'h00000000;
            wait_r <= 1'b1;
        end else begin
            ratio_r <= ratio_nxt;
            config_r <= config_nxt;
            rdata_r <= rdata_nxt;
            wait_r <= wait_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // option shadow and key compare next state
    always_comb begin
        option_nxt = option_r;
        optLoaded_nxt = 1'b1;
        keyBuf_nxt = keyBuf_r;
        keyCount_nxt = keyCount_r;
        keyOrderOk_nxt = keyOrderOk_r;
        keyState_nxt = keyState_r;
        cmd_nxt = 1'b0;
        if (!optLoaded_r) begin
            option_nxt = option_nv_byte;
        end
        if (keyWrite && !config_r[ftsr_pkg::KeyModeBit]) begin
            cmd_nxt = 1'b1;
        end
        unique case (keyState_r)
            ftsr_pkg::FTSR_KEY_IDLE: begin
                if (config_r[ftsr_pkg::KeyModeBit]) begin
                    keyCount_nxt = 4'h0;
                    keyOrderOk_nxt = 1'b1;
                    keyState_nxt = ftsr_pkg::FTSR_KEY_LOAD;
                end
            end
            ftsr_pkg::FTSR_KEY_LOAD: begin
                if (keyWrite && keySrcSecure) begin
                    if (keyCount_r < 4'(ftsr_pkg::KeyBytes)
                        && keyIndex == keyCount_r[2:0]) begin
                        keyBuf_nxt[keyIndex*8 +: 8] = keyData;
                        keyCount_nxt = keyCount_r + 4'h1;
                    end else begin
                        keyOrderOk_nxt = 1'b0;
                    end
                end
                if (keyModeFall) begin
                    keyState_nxt = ftsr_pkg::FTSR_KEY_DONE;
                end
            end
            ftsr_pkg::FTSR_KEY_DONE: begin
                if (option_r[ftsr_pkg::UnlockAllowBit] && keyOrderOk_r
                    && keyCount_r == 4'(ftsr_pkg::KeyBytes)
                    && keyBuf_r == backdoor_key_bytes) begin
                    option_nxt[1:0] = ftsr_pkg::SecUnsecured;
                end
                keyState_nxt = ftsr_pkg::FTSR_KEY_IDLE;
            end
            default: keyState_nxt = ftsr_pkg::FTSR_KEY_IDLE;
        endcase
        if (blankCheckPass && optLoaded_r) begin
            option_nxt[1:0] = ftsr_pkg::SecUnsecured;
        end
    end

    // option shadow and key registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            option_r <= ftsr_pkg::OptionReset;
            optLoaded_r <= 1'b0;
            keyBuf_r <= 64'h0000000000000000;
            keyCount_r <= 4'h0;
            keyOrderOk_r <= 1'b0;
            keyState_r <= ftsr_pkg::FTSR_KEY_IDLE;
            cmd_r <= 1'b0;
        end else begin
            option_r <= option_nxt;
            optLoaded_r <= optLoaded_nxt;
            keyBuf_r <= keyBuf_nxt;
            keyCount_r <= keyCount_nxt;
            keyOrderOk_r <= keyOrderOk_nxt;
            keyState_r <= keyState_nxt;
            cmd_r <= cmd_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // gating outputs next state
    always_comb begin
        grant_nxt = progEraseReq && ratio_r[ftsr_pkg::RatioLoadedBit];
        refused_nxt = progEraseReq && !ratio_r[ftsr_pkg::RatioLoadedBit];
        memAllow_nxt = memAccessReq && (memSrcSecure || !isSecure(option_r[1:0]));
        redirect_nxt = optLoaded_r && !option_r[ftsr_pkg::RedirectOffBit];
    end

    // gating output registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            grant_r <= 1'b0;
            refused_r <= 1'b0;
            memAllow_r <= 1'b0;
            redirect_r <= 1'b0;
            pulse_r <= 1'b0;
        end else begin
            grant_r <= grant_nxt;
            refused_r <= refused_nxt;
            memAllow_r <= memAllow_nxt;
            redirect_r <= redirect_nxt;
            pulse_r <= tb.tick;
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign progEraseGrant = grant_r;
    assign progEraseRefused = refused_r;
    assign cmdStart = cmd_r;
    assign memAccessAllow = memAllow_r;
    assign vectorRedirectOn = redirect_r;
    assign timebasePulse = pulse_r;
endmodule
`default_nettype wire

// ===== verification/ftsr_regs_sva.sv
// checker: port assertions for the flash timebase register block
`default_nettype none
module ftsr_regs_sva (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic keyWrite,
    input wire logic memAccessReq,
    input wire logic memSrcSecure,
    input wire logic progEraseReq,
    input wire logic progEraseGrant,
    input wire logic progEraseRefused,
    input wire logic cmdStart,
    input wire logic memAccessAllow,
    input wire logic vectorRedirectOn,
    input wire logic timebasePulse
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////
    // bus handshake and read data
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest)
        else $error("request not accepted after one cycle");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_upper_zero: assert property (avs_read && !avs_waitrequest
        |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    // program and erase answer
    a_grant_excl: assert property (progEraseReq |=> progEraseGrant != progEraseRefused)
        else $error("program request not answered once");
    a_grant_idle: assert property (!progEraseReq |=> !progEraseGrant && !progEraseRefused)
        else $error("program answer without request");
    // key window, memory access and vector redirect
    a_cmd_cause: assert property (cmdStart |-> $past(keyWrite))
        else $error("command start without key window write");
    a_mem_secure: assert property (memAccessReq && memSrcSecure |=> memAccessAllow)
        else $error("secure source access refused");
    a_redirect_hold: assert property ($past(rstn) && $past(rstn, 2) && $past(rstn, 3)
        |-> $stable(vectorRedirectOn))
        else $error("redirect changed without reset");
    c_pulse: cover property (timebasePulse);
    c_cmd: cover property (cmdStart);
    c_grant: cover property (progEraseGrant);
endmodule
`default_nettype wire

// ===== verification/flash_timebase_security_regs_tb.sv
// testbench: directed scenarios for the flash timebase register block
`default_nettype none
module flash_timebase_security_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [63:0] Key = 64'h0123456789ABCDEF;
    logic sys_clk = 1'h0;
    logic rstn = 1'h0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [7:0] option_nv_byte = 8'hFF;
    logic keyWrite = 1'h0;
    logic [2:0] keyIndex = 3'h0;
    logic [7:0] keyData = 8'h00;
    logic keySrcSecure = 1'h0;
    logic blankCheckPass = 1'h0;
    logic memAccessReq = 1'h0;
    logic memSrcSecure = 1'h0;
    logic progEraseReq = 1'h0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, progEraseGrant, progEraseRefused, cmdStart;
    logic memAccessAllow, vectorRedirectOn, timebasePulse;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    flash_timebase_security_regs dut_u (.sys_clk, .rstn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .option_nv_byte,
        .backdoor_key_bytes(Key), .keyWrite, .keyIndex, .keyData, .keySrcSecure,
        .blankCheckPass, .memAccessReq, .memSrcSecure, .progEraseReq, .progEraseGrant,
        .progEraseRefused, .cmdStart, .memAccessAllow, .vectorRedirectOn, .timebasePulse);
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one avalon transfer, held until waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        do @(posedge sys_clk); while (avs_waitrequest !== 1'h0 && cyc < 20000);
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        bus(1'h0, a, 8'h00);
        chk(rd, exp);
    endtask
    task automatic rst(input logic [7:0] nv);
        rstn <= 1'h0;
        option_nv_byte <= nv;
        progEraseReq <= 1'h0;
        memAccessReq <= 1'h0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'h1;
        @(posedge sys_clk);
    endtask
    // cycles between two timebase pulses
    task automatic period(input int exp);
        int n;
        n = 0;
        while (timebasePulse !== 1'h1 && n < 300) begin
            @(posedge sys_clk);
            n++;
        end
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (timebasePulse !== 1'h1 && n < 300);
        chk(n, exp);
    endtask
    // key bytes in index order, two idle cycles between writes
    task automatic key_seq(input logic sec, input logic mode);
        bus(1'h1, ftsr_pkg::ConfigOffset, {2'h0, mode, 5'h00});
        for (int i = 0; i < ftsr_pkg::KeyBytes; i++) begin
            @(posedge sys_clk);
            keyWrite <= 1'h1;
            keyIndex <= 3'(i);
            keyData <= Key[8*i +: 8];
            keySrcSecure <= sec;
            @(posedge sys_clk);
            keyWrite <= 1'h0;
            @(posedge sys_clk);
            chk(cmdStart, !mode);
        end
        bus(1'h1, ftsr_pkg::ConfigOffset, 8'h00);
        repeat (3) @(posedge sys_clk);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_div();
        rst(8'hFF);
        progEraseReq <= 1'h1;
        repeat (2) @(posedge sys_clk);
        chk(progEraseRefused, 1'h1);
        rdc(ftsr_pkg::RatioOffset, 32'h0);
        bus(1'h1, ftsr_pkg::RatioOffset, 8'h42);
        rdc(ftsr_pkg::RatioOffset, 32'hC2);
        bus(1'h1, ftsr_pkg::RatioOffset, 8'h05);
        rdc(ftsr_pkg::RatioOffset, 32'hC2);
        chk(progEraseGrant, 1'h1);
        period(24);
        rst(8'hFF);
        bus(1'h1, ftsr_pkg::RatioOffset, 8'h83);
        rdc(ftsr_pkg::RatioOffset, 32'h83);
        period(4);
        // recommended fast bus setting: prescale on, ratio 12
        rst(8'hFF);
        bus(1'h1, ftsr_pkg::RatioOffset, 8'h4C);
        period(104);
        // in-window setting for this clock: prescale on, ratio 16, 5.44 us
        rst(8'hFF);
        bus(1'h1, ftsr_pkg::RatioOffset, 8'h50);
        period(136);
        $display("test divider done");
    endtask
    task automatic t_sec();
        for (int s = 0; s < 4; s++) begin
            rst({6'h20, 2'(s)});
            memAccessReq <= 1'h1;
            repeat (2) @(posedge sys_clk);
            chk(memAccessAllow, s == 2);
            chk(vectorRedirectOn, 1'h1);
            memSrcSecure <= 1'h1;
            repeat (2) @(posedge sys_clk);
            chk(memAccessAllow, 1'h1);
            memSrcSecure <= 1'h0;
        end
        rdc(ftsr_pkg::OptionOffset, 32'h83);
        bus(1'h1, ftsr_pkg::OptionOffset, 8'h02);
        rdc(ftsr_pkg::OptionOffset, 32'h83);
        key_seq(1'h1, 1'h1);
        rdc(ftsr_pkg::OptionOffset, 32'h82);
        chk(memAccessAllow, 1'h1);
        rst(8'h83);
        key_seq(1'h1, 1'h0);
        rdc(ftsr_pkg::OptionOffset, 32'h83);
        rst(8'h83);
        key_seq(1'h0, 1'h1);
        rdc(ftsr_pkg::OptionOffset, 32'h83);
        rst(8'h43);
        key_seq(1'h1, 1'h1);
        rdc(ftsr_pkg::OptionOffset, 32'h43);
        chk(vectorRedirectOn, 1'h0);
        blankCheckPass <= 1'h1;
        @(posedge sys_clk);
        blankCheckPass <= 1'h0;
        repeat (2) @(posedge sys_clk);
        rdc(ftsr_pkg::OptionOffset, 32'h42);
        $display("test security done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        t_div();
        t_sec();
        end_of_test();
    end
endmodule
bind flash_timebase_security_regs ftsr_regs_sva chk_u (.sys_clk(sys_clk), .rstn(rstn),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .keyWrite(keyWrite), .memAccessReq(memAccessReq),
    .memSrcSecure(memSrcSecure), .progEraseReq(progEraseReq), .progEraseGrant(progEraseGrant),
    .progEraseRefused(progEraseRefused), .cmdStart(cmdStart), .memAccessAllow(memAccessAllow),
    .vectorRedirectOn(vectorRedirectOn), .timebasePulse(timebasePulse));
`default_nettype wire
